// file: src/tks_pkg.sv
package tks_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 25;

    // Relay pull-in or drop-out settle time, and RF hold-off after key release
    localparam int RELAY_SETTLE_NS = 10_000_000;
    localparam int RF_HOLD_NS      = 10_000_000;

    // Least times, so round up to whole cycles and never below one
    localparam int RELAY_SETTLE_CYC =
        (RELAY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (RELAY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RF_HOLD_CYC =
        (RF_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (RF_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Delay counter width, enough for the default counts
    localparam int CNT_W = 20;

    // Synchroniser layout: bit positions of the sampled pins
    localparam int SYNC_W       = 3;
    localparam int SYNC_KEY_BIT = 0;
    localparam int SYNC_TALK_BIT = 1;
    localparam int SYNC_BKI_BIT = 2;

    // Reset values: request lines idle high, break-in off
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 3'h3;

    // Sequencer states
    typedef enum logic [2:0] {
        TKS_IDLE       = 3'b000,
        TKS_ANT_SETTLE = 3'b001,
        TKS_IN_SETTLE  = 3'b010,
        TKS_TX         = 3'b011,
        TKS_HOLD       = 3'b100,
        TKS_IN_RELEASE = 3'b101
    } tks_state_type;

endpackage

// file: src/tks_sync.sv
`timescale 1ns/1ps
module tks_sync (
    core_clk,
    rst,
    async_in,
    sync_out
);
    import tks_pkg::*;

    input  wire logic              core_clk;
    input  wire logic              rst;
    input  wire logic [SYNC_W-1:0] async_in;
    output logic      [SYNC_W-1:0] sync_out;

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] stable_q;

    ////////////////////////////////////////////////////////////////////////////
    // Two flops per pin; the first stage is read only by the second
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        always_ff @(posedge core_clk) begin
            if (rst) begin
                meta_q[i]   <= SYNC_RST_VAL[i];
                stable_q[i] <= SYNC_RST_VAL[i];
            end else begin
                meta_q[i]   <= async_in[i];
                stable_q[i] <= meta_q[i];
            end
        end
    end

    assign sync_out = stable_q;

endmodule // tks_sync

// file: src/tks_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Break-in key request pulls antenna relay to transmit
// - Break-in grant asserted only after relays transmit
// - Hold-off after key release before relays return
// - Talk request: antenna relay switches first
// - Input relay only after antenna relay settled
// - Talk release: input relay off, then antenna
// - Break-in select picks which request drives sequencer
// - Key pulse delayed until relays reach transmit
// - Grant released immediately when the selected request drops
// - Relays held in transmit until RF ceases
// - Break-in mode ignores talk request entirely
// - Key request ignored outside break-in mode
module tks_sequencer #(
    parameter int SETTLE_CYC = tks_pkg::RELAY_SETTLE_CYC,
    parameter int HOLD_CYC   = tks_pkg::RF_HOLD_CYC
) (
    core_clk,
    rst,
    key_request_n,
    talk_request_input_n,
    full_break_in_select,
    antenna_relay_q,
    input_relay_q,
    key_grant_n_q,
    transmit_busy_q
);
    import tks_pkg::*;

    input  wire logic core_clk;
    input  wire logic rst;
    input  wire logic key_request_n;
    input  wire logic talk_request_input_n;
    input  wire logic full_break_in_select;
    output logic      antenna_relay_q;
    output logic      input_relay_q;
    output logic      key_grant_n_q;
    output logic      transmit_busy_q;

    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD   = CNT_W'(HOLD_CYC - 1);

    logic [SYNC_W-1:0] pins_s;
    wire  logic        key_n_s;
    wire  logic        talk_n_s;
    wire  logic        bki_s;
    wire  logic        request;
    wire  logic        cnt_done;
    wire  logic        state_change;
    wire  logic        load_hold;

    tks_state_type     state_q;
    tks_state_type     state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic              mode_q;
    logic              mode_d;
    logic              antenna_d;
    logic              input_d;
    logic              grant_n_d;

    ////////////////////////////////////////////////////////////////////////////
    // Pins come from the exciter side, so they pass a synchroniser first
    tks_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({full_break_in_select, talk_request_input_n, key_request_n}),
        .sync_out (pins_s)
    );

    assign key_n_s  = pins_s[SYNC_KEY_BIT];
    assign talk_n_s = pins_s[SYNC_TALK_BIT];
    assign bki_s    = pins_s[SYNC_BKI_BIT];

    // Mode select steers exactly one request into the sequencer
    assign request = bki_s ? !key_n_s : !talk_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Delay counter: reload on each state change, else count down to zero
    assign cnt_done     = (cnt_q == '0);
    assign state_change = (state_d != state_q);
    assign load_hold    = (state_d == TKS_HOLD);
    assign cnt_d = state_change ? (load_hold ? HOLD_LOAD : SETTLE_LOAD)
                 : (cnt_done ? cnt_q : cnt_q - CNT_W'(1));

    // Mode is frozen at the start of a sequence for the grant only; the request
    // still follows the live select, so a switch flip mid-over swaps sources
    assign mode_d = (state_q == TKS_IDLE) ? bki_s : mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            TKS_IDLE: begin
                if (request) begin
                    state_d = TKS_ANT_SETTLE;
                end
            end
            TKS_ANT_SETTLE: begin
                if (cnt_done) begin
                    state_d = request ? TKS_IN_SETTLE : TKS_IDLE;
                end
            end
            TKS_IN_SETTLE: begin
                if (cnt_done) begin
                    state_d = request ? TKS_TX : TKS_IN_RELEASE;
                end
            end
            TKS_TX: begin
                if (!request) begin
                    state_d = TKS_HOLD;
                end
            end
            TKS_HOLD: begin
                if (request) begin
                    state_d = TKS_TX; // Re-key while relays still in transmit
                end else if (cnt_done) begin
                    state_d = TKS_IN_RELEASE;
                end
            end
            TKS_IN_RELEASE: begin
                if (cnt_done) begin
                    state_d = TKS_IDLE;
                end
            end
            default: begin
                state_d = TKS_IDLE;
            end
        endcase
    end

    // Relay and grant levels follow the next state so outputs are registered
    assign antenna_d = (state_d != TKS_IDLE);
    assign input_d   = (state_d == TKS_IN_SETTLE) || (state_d == TKS_TX)
                    || (state_d == TKS_HOLD);
    assign grant_n_d = !((state_d == TKS_TX) && mode_d);

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= TKS_IDLE;
            cnt_q   <= '0;
            mode_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            mode_q  <= mode_d;
        end
    end

    // Output registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            antenna_relay_q <= 1'b0;
            input_relay_q   <= 1'b0;
            key_grant_n_q   <= 1'b1;
            transmit_busy_q <= 1'b0;
        end else begin
            antenna_relay_q <= antenna_d;
            input_relay_q   <= input_d;
            key_grant_n_q   <= grant_n_d;
            transmit_busy_q <= (state_d == TKS_TX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    break_in_key_a: assert property (
        (state_q == TKS_IDLE) && bki_s && !key_n_s |=> antenna_relay_q)
        else $error("break-in key did not engage antenna relay");

    grant_needs_relays_a: assert property (
        !key_grant_n_q |-> antenna_relay_q && input_relay_q
            && $past(input_relay_q))
        else $error("grant asserted before relays in transmit");

    input_after_ant_a: assert property (
        $rose(input_relay_q) |-> $past(antenna_relay_q, 1)
            && $past(antenna_relay_q, 2))
        else $error("input relay engaged before antenna relay");

    ant_after_input_a: assert property (
        $fell(antenna_relay_q) |-> !input_relay_q && !$past(input_relay_q))
        else $error("antenna relay released before input relay");

    grant_drop_fast_a: assert property (
        !key_grant_n_q && !request |=> key_grant_n_q)
        else $error("grant not released on key release");

    relay_hold_a: assert property (
        $rose(key_grant_n_q) |=> antenna_relay_q && input_relay_q)
        else $error("relays dropped without hold-off");

    talk_ignored_a: assert property (
        (state_q == TKS_IDLE) && bki_s && key_n_s |=> state_q == TKS_IDLE)
        else $error("talk request acted on in break-in mode");

    key_ignored_a: assert property (
        (state_q == TKS_IDLE) && !bki_s && talk_n_s |=> !antenna_relay_q)
        else $error("key request acted on outside break-in mode");

    settle_count_a: assert property (
        (state_q == TKS_ANT_SETTLE) && !cnt_done |=> state_q == TKS_ANT_SETTLE)
        else $error("antenna settle cut short");

    break_in_grant_c: cover property ($fell(key_grant_n_q));
    talk_over_c: cover property ($rose(input_relay_q) && !mode_q);
    rekey_hold_c: cover property ((state_q == TKS_HOLD) && request);

endmodule // tks_sequencer

// file: sim/tks_exciter.sv
`timescale 1ns/1ps
// Exciter model: turns the bench's key and talk commands into pin levels
module tks_exciter (
    key_press,
    ptt_press,
    key_grant_n_q,
    key_request_n,
    talk_request_input_n,
    rf_on
);
    input  wire logic key_press;
    input  wire logic ptt_press;
    input  wire logic key_grant_n_q;
    output logic      key_request_n;
    output logic      talk_request_input_n;
    output logic      rf_on;

    ////////////////////////////////////////////////////////////////////////
    // Request lines are grounded while keyed, idle high otherwise
    assign key_request_n        = ~key_press;
    assign talk_request_input_n = ~ptt_press;

    // RF only while granted and still keyed, so release stops RF at once
    assign rf_on = ~key_grant_n_q & key_press;
endmodule // tks_exciter

// file: sim/tb_tks_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_tks_sequencer;
    import tks_pkg::*;
    logic       core_clk             = 1'b0;
    logic       rst                  = 1'b1;
    logic       key_press            = 1'b0;
    logic       ptt_press            = 1'b0;
    logic       full_break_in_select = 1'b0;
    logic       key_request_n;
    logic       talk_request_input_n;
    logic       antenna_relay_q;
    logic       input_relay_q;
    logic       key_grant_n_q;
    logic       transmit_busy_q;
    logic       rf_on;
    logic [3:0] exp_q[$];
    logic [3:0] last_q = 4'h2;
    logic [3:0] e;
    int         n_errors    = 0;
    int         checks_done = 0;
    int         seed        = 7824;
    wire  [3:0] outs = {antenna_relay_q, input_relay_q, key_grant_n_q, transmit_busy_q};

    always #12.5 core_clk = ~core_clk;

    // Short settle and hold counts keep the run brief
    tks_sequencer #(.SETTLE_CYC(2), .HOLD_CYC(3)) u_tks_sequencer (
        .core_clk            (core_clk),
        .rst                 (rst),
        .key_request_n       (key_request_n),
        .talk_request_input_n(talk_request_input_n),
        .full_break_in_select(full_break_in_select),
        .antenna_relay_q     (antenna_relay_q),
        .input_relay_q       (input_relay_q),
        .key_grant_n_q       (key_grant_n_q),
        .transmit_busy_q     (transmit_busy_q)
    );

    tks_exciter u_tks_exciter (
        .key_press           (key_press),
        .ptt_press           (ptt_press),
        .key_grant_n_q       (key_grant_n_q),
        .key_request_n       (key_request_n),
        .talk_request_input_n(talk_request_input_n),
        .rf_on               (rf_on)
    );

    ////////////////////////////////////////////////////////////////////////
    // Watcher: every output change must be the oldest expected step
    always @(posedge core_clk) begin
        #1;
        if (!rst && outs !== last_q) begin
            if (exp_q.size() == 0) begin
                `CHK(outs, last_q)
            end else begin
                e = exp_q.pop_front();
                `CHK(outs, e)
            end
            last_q = outs;
        end
        // RF must never flow unless both relays are in transmit
        if (rf_on) `CHK({antenna_relay_q, input_relay_q}, 2'h3)
    end

    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Full keyed cycle in either mode, random key length
    task automatic burst(input logic bki);
        int len;
        len = 12 + ($random(seed) & 7);
        exp_q.push_back(4'ha);
        exp_q.push_back(4'he);
        exp_q.push_back(bki ? 4'hd : 4'hf);
        exp_q.push_back(4'he);
        exp_q.push_back(4'ha);
        exp_q.push_back(4'h2);
        @(negedge core_clk);
        if (bki) key_press = 1'b1;
        else ptt_press = 1'b1;
        repeat (len) @(negedge core_clk);
        key_press = 1'b0;
        ptt_press = 1'b0;
        repeat (30) @(negedge core_clk);
        `CHK(exp_q.size(), 0)
        $display("burst test done, mode=%0d", bki);
    endtask

    // The pin that does not belong to the mode must cause no change
    task automatic ignored(input logic bki);
        @(negedge core_clk);
        if (bki) ptt_press = 1'b1;
        else key_press = 1'b1;
        // Random chatter on the foreign pin, so every edge of it is tried
        repeat (20) begin
            @(negedge core_clk);
            if (bki) ptt_press = 1'($random(seed));
            else key_press = 1'($random(seed));
        end
        @(negedge core_clk);
        key_press = 1'b0;
        ptt_press = 1'b0;
        repeat (5) @(negedge core_clk);
        `CHK(outs, 4'h2)
        $display("ignore test done, mode=%0d", bki);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: both modes, twice each
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            full_break_in_select = i[0];
            repeat (4) @(negedge core_clk);
            burst(i[0]);
            ignored(i[0]);
        end
        end_sim();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 5000);
        n_errors++;
        end_sim();
    end
endmodule // tb_tks_sequencer
